// ==== pkg/odc_consts.svh ====
// Purpose: named constants for the display command decoder
// Assumes: byte-wide command stream
// Notes:   command codes, reset values and field limits
`ifndef ODC_CONSTS_SVH
`define ODC_CONSTS_SVH
`define ODC_CMD_GRAY_EN     8'h00
`define ODC_CMD_COL_ADDR    8'h15
`define ODC_CMD_RAM_WRITE   8'h5C
`define ODC_CMD_RAM_READ    8'h5D
`define ODC_CMD_ROW_ADDR    8'h75
`define ODC_CMD_REMAP       8'hA0
`define ODC_CMD_START_LINE  8'hA1
`define ODC_CMD_OFFSET      8'hA2
`define ODC_CMD_ALL_OFF     8'hA4
`define ODC_CMD_ALL_ON      8'hA5
`define ODC_CMD_NORMAL      8'hA6
`define ODC_CMD_INVERSE     8'hA7
`define ODC_CMD_PART_ON     8'hA8
`define ODC_CMD_PART_OFF    8'hA9
`define ODC_CMD_VDD_SEL     8'hAB
`define ODC_COL_END_RST     7'h77
`define ODC_ROW_END_RST     7'h7F
`define ODC_COL_MAX         7'h77
`define ODC_ZERO7           7'h00
`define ODC_ZERO8           8'h00
`define ODC_REMAP_B_MASK    8'h10
`define ODC_GRAY_MAX        4'hF
`define ODC_GRAY_MIN        4'h0
`endif

// ==== pkg/odc_pkg.sv ====
// Purpose: types for the display command decoder
// Assumes: nothing
// Notes:   modes and parameter-collection states
package odc_pkg;
  typedef enum logic [1:0] {
    ODC_MODE_ALL_OFF,
    ODC_MODE_ALL_ON,
    ODC_MODE_NORMAL,
    ODC_MODE_INVERSE
  } odc_mode_t;
  typedef enum logic [1:0] {
    ODC_RAM_IDLE,
    ODC_RAM_WRITE,
    ODC_RAM_READ
  } odc_ram_t;
  typedef enum logic [3:0] {
    ODC_ST_CMD,
    ODC_ST_COL_A,
    ODC_ST_COL_B,
    ODC_ST_ROW_A,
    ODC_ST_ROW_B,
    ODC_ST_REMAP_A,
    ODC_ST_REMAP_B,
    ODC_ST_START,
    ODC_ST_OFFSET,
    ODC_ST_PART_A,
    ODC_ST_PART_B,
    ODC_ST_VDD
  } odc_state_t;
endpackage

// ==== pkg/odc_byte_if.sv ====
// Purpose: carries one framed byte from the front end to the decoder
// Assumes: single clock
// Notes:   valid qualifies one byte in each cycle it is high; back-to-back bytes keep it high
`timescale 1ns/1ps
`default_nettype none
interface odc_byte_if;
  logic       valid;
  logic       is_data;
  logic [7:0] value;
  modport src (output valid, output is_data, output value);
  modport dst (input valid, input is_data, input value);
endinterface
`default_nettype wire

// ==== logic/odc_gray_map.sv ====
// Purpose: maps a stored gray level to the shown level by display mode
// Assumes: 4-bit gray levels
// Notes:   combinational; result registered by the caller
`timescale 1ns/1ps
`default_nettype none
module odc_gray_map (
  input  wire odc_pkg::odc_mode_t mode_in,
  input  wire logic [3:0]         level_in,
  output logic [3:0]              level_out
);
  import odc_pkg::*;
`include "odc_consts.svh"
  always_comb begin
    case (mode_in)
      ODC_MODE_ALL_OFF: level_out = `ODC_GRAY_MIN;
      ODC_MODE_ALL_ON:  level_out = `ODC_GRAY_MAX;
      ODC_MODE_INVERSE: level_out = `ODC_GRAY_MAX - level_in;
      default:          level_out = level_in;
    endcase
  end
endmodule // odc_gray_map
`default_nettype wire

// ==== logic/odc_decoder.sv ====
// Purpose: command decoder holding the display driver settings
// Assumes: one byte strobe per transfer, synchronous to clk_in
// Notes:   settings commit on the last parameter of a command
// Summary of operation
// - command 00h enables custom gray table
// - 15h sets column window, reset 0/119
// - after 5Ch data bytes are RAM writes
// - after 5Dh host reads RAM data
// - 75h sets row window, reset 0/127
// - A1h loads start line, reset zero
// - A2h loads vertical offset, reset zero
// - A4h forces all pixels level 0
// - A5h forces all pixels level 15
// - A6h normal display, default after reset
// - A7h inverse display, fifteen minus level
// - A8h enables partial mode with rows
// - A9h exits partial display mode
// - ABh selects internal or external regulator
// - data select high data, low command
// - transfers only while chip select low
// - reset low restores all defaults
`timescale 1ns/1ps
`default_nettype none
module odc_decoder (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        strobe_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        data_not_command_select_in,
  input  wire logic [7:0]  bus_data_in,
  input  wire logic [3:0]  pixel_level_in,
  output logic             gray_table_en_out,
  output logic [6:0]       col_start_out,
  output logic [6:0]       col_end_out,
  output logic [6:0]       row_start_out,
  output logic [6:0]       row_end_out,
  output logic [7:0]       remap_a_out,
  output logic [7:0]       remap_b_out,
  output logic [6:0]       start_line_out,
  output logic [6:0]       offset_out,
  output odc_pkg::odc_mode_t mode_out,
  output logic             partial_en_out,
  output logic [6:0]       part_start_out,
  output logic [6:0]       part_end_out,
  output logic             vdd_internal_out,
  output logic             ram_write_out,
  output logic             ram_read_out,
  output logic [7:0]       ram_data_out,
  output logic [3:0]       shown_level_out
);
  import odc_pkg::*;
`include "odc_consts.svh"

  // ==========================================================
  // byte framing
  odc_byte_if bif ();
  assign bif.valid   = strobe_in && !chip_select_n_in;
  assign bif.is_data = data_not_command_select_in;
  assign bif.value   = bus_data_in;

  // ==========================================================
  // state
  typedef struct packed {
    odc_state_t st;
    logic [6:0] hold;
    logic [7:0] hold8;
    logic       gray_en;
    logic [6:0] col_s;
    logic [6:0] col_e;
    logic [6:0] row_s;
    logic [6:0] row_e;
    logic [7:0] rm_a;
    logic [7:0] rm_b;
    logic [6:0] sline;
    logic [6:0] offs;
    odc_mode_t  mode;
    logic       part;
    logic [6:0] p_s;
    logic [6:0] p_e;
    logic       vdd_int;
    odc_ram_t   ram;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [3:0] shown;
  } odc_state_reg_t;

  odc_state_reg_t s_reg;
  odc_state_reg_t s_next;
  logic [3:0]     mapped;

  odc_gray_map u_map (
    .mode_in   (s_reg.mode),
    .level_in  (pixel_level_in),
    .level_out (mapped)
  );

  function automatic logic [6:0] clip_col(input logic [6:0] v);
    clip_col = (v > `ODC_COL_MAX) ? `ODC_COL_MAX : v;
  endfunction

  always_comb begin
    s_next       = s_reg;
    s_next.wr    = 1'b0;
    s_next.rd    = 1'b0;
    s_next.shown = mapped;
    if (bif.valid && !bif.is_data) begin
      // a new command aborts any unfinished parameter collection
      s_next.st  = ODC_ST_CMD;
      s_next.ram = ODC_RAM_IDLE;
      case (bif.value)
        `ODC_CMD_GRAY_EN:    s_next.gray_en = 1'b1;
        `ODC_CMD_COL_ADDR:   s_next.st = ODC_ST_COL_A;
        `ODC_CMD_RAM_WRITE:  s_next.ram = ODC_RAM_WRITE;
        `ODC_CMD_RAM_READ:   s_next.ram = ODC_RAM_READ;
        `ODC_CMD_ROW_ADDR:   s_next.st = ODC_ST_ROW_A;
        `ODC_CMD_REMAP:      s_next.st = ODC_ST_REMAP_A;
        `ODC_CMD_START_LINE: s_next.st = ODC_ST_START;
        `ODC_CMD_OFFSET:     s_next.st = ODC_ST_OFFSET;
        `ODC_CMD_ALL_OFF:    s_next.mode = ODC_MODE_ALL_OFF;
        `ODC_CMD_ALL_ON:     s_next.mode = ODC_MODE_ALL_ON;
        `ODC_CMD_NORMAL:     s_next.mode = ODC_MODE_NORMAL;
        `ODC_CMD_INVERSE:    s_next.mode = ODC_MODE_INVERSE;
        `ODC_CMD_PART_ON:    s_next.st = ODC_ST_PART_A;
        `ODC_CMD_PART_OFF:   s_next.part = 1'b0;
        `ODC_CMD_VDD_SEL:    s_next.st = ODC_ST_VDD;
        default:             s_next.st = ODC_ST_CMD;
      endcase
    end else if (bif.valid && bif.is_data) begin
      // top bit of seven-bit parameters is don't-care
      case (s_reg.st)
        ODC_ST_COL_A: begin
          s_next.hold = bif.value[6:0];
          s_next.st   = ODC_ST_COL_B;
        end
        ODC_ST_COL_B: begin
          s_next.col_s = clip_col(s_reg.hold);
          s_next.col_e = clip_col(bif.value[6:0]);
          s_next.st    = ODC_ST_CMD;
        end
        ODC_ST_ROW_A: begin
          s_next.hold = bif.value[6:0];
          s_next.st   = ODC_ST_ROW_B;
        end
        ODC_ST_ROW_B: begin
          s_next.row_s = s_reg.hold;
          s_next.row_e = bif.value[6:0];
          s_next.st    = ODC_ST_CMD;
        end
        ODC_ST_REMAP_A: begin
          s_next.hold8 = bif.value;
          s_next.st    = ODC_ST_REMAP_B;
        end
        ODC_ST_REMAP_B: begin
          s_next.rm_a = s_reg.hold8;
          s_next.rm_b = bif.value & `ODC_REMAP_B_MASK;
          s_next.st   = ODC_ST_CMD;
        end
        ODC_ST_START: begin
          s_next.sline = bif.value[6:0];
          s_next.st    = ODC_ST_CMD;
        end
        ODC_ST_OFFSET: begin
          s_next.offs = bif.value[6:0];
          s_next.st   = ODC_ST_CMD;
        end
        ODC_ST_PART_A: begin
          s_next.hold = bif.value[6:0];
          s_next.st   = ODC_ST_PART_B;
        end
        ODC_ST_PART_B: begin
          // end below start is the host's fault; stored as sent
          s_next.p_s  = s_reg.hold;
          s_next.p_e  = bif.value[6:0];
          s_next.part = 1'b1;
          s_next.st   = ODC_ST_CMD;
        end
        ODC_ST_VDD: begin
          s_next.vdd_int = bif.value[0];
          s_next.st      = ODC_ST_CMD;
        end
        default: begin
          if (s_reg.ram == ODC_RAM_WRITE) begin
            s_next.wr    = 1'b1;
            s_next.wdata = bif.value;
          end else if (s_reg.ram == ODC_RAM_READ) begin
            s_next.rd = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg         <= '0;
      s_reg.st      <= ODC_ST_CMD;
      s_reg.col_e   <= `ODC_COL_END_RST;
      s_reg.row_e   <= `ODC_ROW_END_RST;
      s_reg.mode    <= ODC_MODE_NORMAL;
      s_reg.vdd_int <= 1'b1;
      s_reg.ram     <= ODC_RAM_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign gray_table_en_out = s_reg.gray_en;
  assign col_start_out     = s_reg.col_s;
  assign col_end_out       = s_reg.col_e;
  assign row_start_out     = s_reg.row_s;
  assign row_end_out       = s_reg.row_e;
  assign remap_a_out       = s_reg.rm_a;
  assign remap_b_out       = s_reg.rm_b;
  assign start_line_out    = s_reg.sline;
  assign offset_out        = s_reg.offs;
  assign mode_out          = s_reg.mode;
  assign partial_en_out    = s_reg.part;
  assign part_start_out    = s_reg.p_s;
  assign part_end_out      = s_reg.p_e;
  assign vdd_internal_out  = s_reg.vdd_int;
  assign ram_write_out     = s_reg.wr;
  assign ram_read_out      = s_reg.rd;
  assign ram_data_out      = s_reg.wdata;
  assign shown_level_out   = s_reg.shown;

  // ==========================================================
  // checks
  offset_load_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bif.valid && bif.is_data && s_reg.st == ODC_ST_OFFSET)
      |=> offset_out == $past(bus_data_in[6:0]))
    else $error("offset not loaded");
  start_load_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bif.valid && bif.is_data && s_reg.st == ODC_ST_START)
      |=> start_line_out == $past(bus_data_in[6:0]))
    else $error("start line not loaded");
  cs_ignore_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    chip_select_n_in |=> $stable(s_reg.st) && $stable(mode_out) && !ram_write_out)
    else $error("activity while deselected");
  partial_exit_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bif.valid && !bif.is_data && bus_data_in == `ODC_CMD_PART_OFF) |=> !partial_en_out)
    else $error("partial not exited");
  col_commit_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (s_reg.st == ODC_ST_COL_B) |-> $stable(col_start_out))
    else $error("column changed early");
  col_range_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    col_start_out <= `ODC_COL_MAX && col_end_out <= `ODC_COL_MAX)
    else $error("column out of range");
  inverse_map_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mode_out == ODC_MODE_INVERSE && $stable(mode_out))
      |=> shown_level_out == `ODC_GRAY_MAX - $past(pixel_level_in))
    else $error("inverse level wrong");
  write_data_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bif.valid && bif.is_data && s_reg.st == ODC_ST_CMD && s_reg.ram == ODC_RAM_WRITE)
      |=> ram_write_out && ram_data_out == $past(bus_data_in))
    else $error("ram write missed");
  all_on_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (bif.valid && !bif.is_data && bus_data_in == `ODC_CMD_ALL_ON)
      |=> mode_out == ODC_MODE_ALL_ON ##1 shown_level_out == `ODC_GRAY_MAX)
    else $error("all on level wrong");
endmodule // odc_decoder
`default_nettype wire

// ==== testbench/odc_host_model.sv ====
// Purpose: host side model that frames bytes onto the decoder pins
// Assumes: called from the bench, one byte per clock at most
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module odc_host_model (
  input  wire logic       clk_in,
  output logic            strobe_out,
  output logic            chip_select_n_out,
  output logic            data_not_command_select_out,
  output logic [7:0]      bus_data_out
);
  initial begin
    strobe_out = 1'b0;
    chip_select_n_out = 1'b1;
    data_not_command_select_out = 1'b0;
    bus_data_out = 8'h00;
  end
  // =========================================================
  // byte framing
  // cs_n high on purpose gives a stray strobe that must be dropped
  task automatic put(input logic cs_n, input logic dc, input logic [7:0] b);
    @(posedge clk_in);
    #2;
    chip_select_n_out = cs_n;
    data_not_command_select_out = dc;
    bus_data_out = b;
    strobe_out = 1'b1;
  endtask
  task automatic cmd(input logic [7:0] b);
    put(1'b0, 1'b0, b);
  endtask
  task automatic dat(input logic [7:0] b);
    put(1'b0, 1'b1, b);
  endtask
  // a stale byte left on the lines would hide a decoder that samples late
  task automatic idle();
    @(posedge clk_in);
    #2;
    strobe_out = 1'b0;
    chip_select_n_out = 1'b1;
    bus_data_out = ~bus_data_out;
  endtask
endmodule // odc_host_model
`default_nettype wire

// ==== testbench/odc_decoder_tb.sv ====
// Purpose: self-checking bench for the display command decoder
// Assumes: 40 MHz clock; host model frames every byte
// Notes:   outputs are read 2 ns after the edge that updates them
`timescale 1ns/1ps
`default_nettype none
module odc_decoder_tb;
  import odc_pkg::*;
  logic clk_in, reset_n_in, strobe, cs_n, dnc, gray_en, part_en, vdd_int, ram_wr, ram_rd;
  logic [7:0] bus, rm_a, rm_b, ram_d;
  logic [6:0] col_s, col_e, row_s, row_e, st_line, offs, part_s, part_e;
  logic [3:0] pixel, shown;
  odc_mode_t  mode;
  int         err_count;
  int         n_tests;
  odc_host_model i_odc_host_model (
    .clk_in                      (clk_in),
    .strobe_out                  (strobe),
    .chip_select_n_out           (cs_n),
    .data_not_command_select_out (dnc),
    .bus_data_out                (bus)
  );
  odc_decoder i_odc_decoder (
    .clk_in                     (clk_in),
    .reset_n_in                 (reset_n_in),
    .strobe_in                  (strobe),
    .chip_select_n_in           (cs_n),
    .data_not_command_select_in (dnc),
    .bus_data_in                (bus),
    .pixel_level_in             (pixel),
    .gray_table_en_out          (gray_en),
    .col_start_out              (col_s),
    .col_end_out                (col_e),
    .row_start_out              (row_s),
    .row_end_out                (row_e),
    .remap_a_out                (rm_a),
    .remap_b_out                (rm_b),
    .start_line_out             (st_line),
    .offset_out                 (offs),
    .mode_out                   (mode),
    .partial_en_out             (part_en),
    .part_start_out             (part_s),
    .part_end_out               (part_e),
    .vdd_internal_out           (vdd_int),
    .ram_write_out              (ram_wr),
    .ram_read_out               (ram_rd),
    .ram_data_out               (ram_d),
    .shown_level_out            (shown)
  );
  // =========================================================
  // checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // =========================================================
  // scenarios
  task automatic t_defaults();
    chk({7'h00, gray_en}, 8'h00);
    chk({1'b0, col_s}, 8'h00);
    chk({1'b0, col_e}, 8'h77);
    chk({1'b0, row_s}, 8'h00);
    chk({1'b0, row_e}, 8'h7F);
    chk({1'b0, st_line}, 8'h00);
    chk({1'b0, offs}, 8'h00);
    chk({6'h00, mode}, {6'h00, ODC_MODE_NORMAL});
    chk({7'h00, part_en}, 8'h00);
    chk({7'h00, vdd_int}, 8'h01);
  endtask
  task automatic t_windows();
    i_odc_host_model.cmd(8'h15);
    i_odc_host_model.dat(8'h10);
    i_odc_host_model.idle();
    chk({1'b0, col_s}, 8'h00);
    i_odc_host_model.dat(8'h20);
    i_odc_host_model.idle();
    chk({1'b0, col_s}, 8'h10);
    chk({1'b0, col_e}, 8'h20);
    i_odc_host_model.cmd(8'h15);
    i_odc_host_model.dat(8'h7F);
    i_odc_host_model.dat(8'h78);
    i_odc_host_model.cmd(8'h75);
    i_odc_host_model.dat(8'h85);
    i_odc_host_model.dat(8'h7F);
    i_odc_host_model.idle();
    chk({1'b0, col_s}, 8'h77);
    chk({1'b0, col_e}, 8'h77);
    chk({1'b0, row_s}, 8'h05);
    chk({1'b0, row_e}, 8'h7F);
  endtask
  task automatic t_single();
    i_odc_host_model.cmd(8'hA1);
    i_odc_host_model.dat(8'hFF);
    i_odc_host_model.cmd(8'hA2);
    i_odc_host_model.dat(8'h33);
    i_odc_host_model.cmd(8'hAB);
    i_odc_host_model.dat(8'hFE);
    i_odc_host_model.idle();
    chk({1'b0, st_line}, 8'h7F);
    chk({1'b0, offs}, 8'h33);
    chk({7'h00, vdd_int}, 8'h00);
    i_odc_host_model.cmd(8'hAB);
    i_odc_host_model.dat(8'h01);
    i_odc_host_model.cmd(8'h00);
    i_odc_host_model.idle();
    chk({7'h00, vdd_int}, 8'h01);
    chk({7'h00, gray_en}, 8'h01);
  endtask
  task automatic t_modes();
    odc_mode_t  m [4];
    logic [3:0] lv [4];
    m = '{ODC_MODE_ALL_OFF, ODC_MODE_ALL_ON, ODC_MODE_NORMAL, ODC_MODE_INVERSE};
    lv = '{4'h0, 4'hF, 4'h5, 4'h9};
    for (int i = 0; i < 4; i++) begin
      // a different stored level each pass keeps the map input moving
      pixel = 4'h3 + 4'(i);
      i_odc_host_model.cmd(8'hA4 + 8'(i));
      i_odc_host_model.idle();
      chk({6'h00, mode}, {6'h00, m[i]});
      @(posedge clk_in);
      #2;
      chk({4'h0, shown}, {4'h0, lv[i]});
    end
  endtask
  task automatic t_partial();
    i_odc_host_model.cmd(8'hA8);
    i_odc_host_model.dat(8'h0A);
    i_odc_host_model.idle();
    chk({7'h00, part_en}, 8'h00);
    i_odc_host_model.dat(8'h14);
    i_odc_host_model.idle();
    chk({7'h00, part_en}, 8'h01);
    chk({1'b0, part_s}, 8'h0A);
    chk({1'b0, part_e}, 8'h14);
    i_odc_host_model.cmd(8'hA9);
    i_odc_host_model.cmd(8'hA0);
    i_odc_host_model.dat(8'h25);
    i_odc_host_model.dat(8'hFF);
    i_odc_host_model.idle();
    chk({7'h00, part_en}, 8'h00);
    chk(rm_a, 8'h25);
    chk(rm_b, 8'h10);
  endtask
  task automatic t_ram();
    i_odc_host_model.cmd(8'h5C);
    i_odc_host_model.dat(8'hAA);
    i_odc_host_model.idle();
    chk({7'h00, ram_wr}, 8'h01);
    chk(ram_d, 8'hAA);
    i_odc_host_model.cmd(8'hA6);
    i_odc_host_model.dat(8'h55);
    i_odc_host_model.idle();
    chk({7'h00, ram_wr}, 8'h00);
    i_odc_host_model.cmd(8'h5D);
    i_odc_host_model.dat(8'h00);
    i_odc_host_model.idle();
    chk({7'h00, ram_rd}, 8'h01);
    chk({7'h00, ram_wr}, 8'h00);
  endtask
  task automatic t_refuse();
    i_odc_host_model.put(1'b1, 1'b0, 8'hA7);
    i_odc_host_model.idle();
    chk({6'h00, mode}, {6'h00, ODC_MODE_NORMAL});
    i_odc_host_model.put(1'b0, 1'b1, 8'hA4);
    i_odc_host_model.idle();
    chk({6'h00, mode}, {6'h00, ODC_MODE_NORMAL});
    i_odc_host_model.cmd(8'hE3);
    i_odc_host_model.cmd(8'h75);
    i_odc_host_model.dat(8'h01);
    i_odc_host_model.cmd(8'hA6);
    i_odc_host_model.dat(8'h02);
    i_odc_host_model.idle();
    chk({6'h00, mode}, {6'h00, ODC_MODE_NORMAL});
    chk({1'b0, row_s}, 8'h05);
    chk({1'b0, row_e}, 8'h7F);
  endtask
  task automatic t_reset();
    @(posedge clk_in);
    #2;
    reset_n_in = 1'b0;
    @(posedge clk_in);
    #2;
    t_defaults();
    reset_n_in = 1'b1;
    @(posedge clk_in);
    #2;
    t_defaults();
  endtask
  // =========================================================
  // clock, reset, sequence and hang guard
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    err_count = 0;
    n_tests = 0;
    reset_n_in = 1'b0;
    pixel = 4'h0;
    repeat (2) @(posedge clk_in);
    #2;
    reset_n_in = 1'b1;
    t_defaults();
    t_windows();
    t_single();
    t_modes();
    t_partial();
    t_ram();
    t_refuse();
    t_reset();
    results();
  end
  initial begin
    repeat (4000) @(posedge clk_in);
    err_count++;
    results();
  end
endmodule // odc_decoder_tb
`default_nettype wire
